// ==== rtl/ist_timing.sv ====
// Instruction state timing: cycle-kind counts times location costs
`timescale 1ns/10ps
`include "ist_defs.svh"
// How it works
// - Total states are the sum over six cycle kinds of count times cost.
// - Every instruction is split into fetch, branch read, stack, byte, word and internal counts.
// - A byte access to a peripheral costs 2 or 3 states, fixed per module.
// - Bit-set on an 8-bit absolute operand takes two fetches and two byte accesses at 2 states each.
// - Indirect call takes two fetches, one branch read and one stack cycle at 2 states each.
module ist_timing
  import ist_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     start,
  input  ist_class_t                    cls,
  input  wire logic [`IST_CNT_W-1:0]    cnt_fetch,
  input  wire logic [`IST_CNT_W-1:0]    cnt_branch,
  input  wire logic [`IST_CNT_W-1:0]    cnt_stack,
  input  wire logic [`IST_CNT_W-1:0]    cnt_byte,
  input  wire logic [`IST_CNT_W-1:0]    cnt_word,
  input  wire logic [`IST_CNT_W-1:0]    cnt_internal,
  input  wire logic                     data_periph,
  input  wire logic [`IST_PID_W-1:0]    periph_id,
  output logic                          ready,
  output logic                          state_tick,
  output logic                          done_ff,
  output logic      [`IST_TOT_W-1:0]    total_ff
);
  localparam int CW = `IST_CNT_W;
  localparam int TW = `IST_TOT_W;

  ist_state_t          state_ff;
  ist_state_t          nxt_state;
  ist_class_t          cls_ff;
  logic [CW-1:0]       ci_ff, cj_ff, ck_ff, cl_ff, cm_ff, cn_ff;
  logic                per_ff;
  logic [TW-1:0]       remain_ff;
  logic [`IST_COST_W-1:0] per_cost;

  // ==========================================================
  // Split into cycle-kind counts
  wire logic [CW-1:0] pi, pj, pk, pl, pm, pn;
  wire logic          is_cust;
  assign is_cust = (cls == IST_CLS_CUSTOM);
  assign pi = is_cust                     ? cnt_fetch :
              (cls == IST_CLS_ALU_REG)    ? CW'(1) :
              (cls == IST_CLS_IMM32)      ? CW'(3) : CW'(2);
  assign pj = is_cust ? cnt_branch :
              (cls == IST_CLS_CALL) ? CW'(1) : CW'(0);
  assign pk = is_cust ? cnt_stack :
              (cls == IST_CLS_CALL) ? CW'(1) : CW'(0);
  assign pl = is_cust ? cnt_byte :
              (cls == IST_CLS_BITSET) ? CW'(2) : CW'(0);
  assign pm = is_cust ? cnt_word : CW'(0);
  assign pn = is_cust ? cnt_internal : CW'(0);

  wire logic take;
  assign ready = (state_ff == IST_IDLE);
  assign take  = ready && start;

  ist_periph_cost u_cost (
    .clk     (clk),
    .rst_n   (rst_n),
    .pid     (periph_id),
    .cost_ff (per_cost)
  );

  // ==========================================================
  // Cost per kind and total
  wire logic [`IST_COST_W-1:0] data_cost;
  wire logic [TW-1:0]          sum;
  assign data_cost = per_ff ? per_cost : `IST_MEM_COST;
  assign sum = TW'(ci_ff) * TW'(`IST_MEM_COST) +
               TW'(cj_ff) * TW'(`IST_MEM_COST) +
               TW'(ck_ff) * TW'(`IST_MEM_COST) +
               TW'(cl_ff) * TW'(data_cost) +
               TW'(cm_ff) * TW'(data_cost) +
               TW'(cn_ff) * TW'(`IST_INT_COST);

  // ==========================================================
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      IST_IDLE: if (take) nxt_state = IST_LOOK;
      IST_LOOK: nxt_state = IST_CALC;
      IST_CALC: nxt_state = (sum == '0) ? IST_DONE : IST_RUN;
      IST_RUN:  if (remain_ff == TW'(1)) nxt_state = IST_DONE;
      IST_DONE: nxt_state = IST_IDLE;
    endcase
  end

  assign state_tick = (state_ff == IST_RUN);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= IST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cls_ff <= IST_CLS_CUSTOM;
      ci_ff  <= '0;
      cj_ff  <= '0;
      ck_ff  <= '0;
      cl_ff  <= '0;
      cm_ff  <= '0;
      cn_ff  <= '0;
      per_ff <= 1'b0;
    end else if (take) begin
      cls_ff <= cls;
      ci_ff  <= pi;
      cj_ff  <= pj;
      ck_ff  <= pk;
      cl_ff  <= pl;
      cm_ff  <= pm;
      cn_ff  <= pn;
      per_ff <= is_cust && data_periph;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      total_ff  <= '0;
      remain_ff <= '0;
      done_ff   <= 1'b0;
    end else begin
      done_ff <= (nxt_state == IST_DONE);
      if (state_ff == IST_CALC) begin
        total_ff  <= sum;
        remain_ff <= sum;
      end else if (state_tick) begin
        remain_ff <= remain_ff - TW'(1);
      end
    end
  end

  // ==========================================================
  // Checks
  sequence s_take(ist_class_t c);
    take && cls == c;
  endsequence

  a_total_sum : assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == IST_CALC |=> total_ff == $past(sum) && remain_ff == total_ff)
    else $error("total not latched from sum");

  a_run_length : assert property (@(posedge clk) disable iff (!rst_n)
    s_take(IST_CLS_ALU_REG) |-> ##3 state_tick [*2] ##1 done_ff)
    else $error("run length differs from total");

  a_split_bitset : assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == IST_CALC && cls_ff == IST_CLS_BITSET |->
    cj_ff == '0 && ck_ff == '0 && cm_ff == '0 && cn_ff == '0)
    else $error("bit-set uses extra cycle kinds");

  a_bitset_eight : assert property (@(posedge clk) disable iff (!rst_n)
    s_take(IST_CLS_BITSET) |-> ##3 total_ff == TW'(8))
    else $error("bit-set total not 8");

  a_call_eight : assert property (@(posedge clk) disable iff (!rst_n)
    s_take(IST_CLS_CALL) |-> ##3 total_ff == TW'(8))
    else $error("indirect call total not 8");

  a_imm32_six : assert property (@(posedge clk) disable iff (!rst_n)
    s_take(IST_CLS_IMM32) |-> ##3 total_ff == TW'(6))
    else $error("32-bit immediate total not 6");

  a_periph_byte : assert property (@(posedge clk) disable iff (!rst_n)
    take && is_cust && data_periph && cnt_byte == CW'(1) && cnt_fetch == '0
    && cnt_branch == '0 && cnt_stack == '0 && cnt_word == '0
    && cnt_internal == '0 |-> ##3 (total_ff == TW'(2) || total_ff == TW'(3)))
    else $error("peripheral byte access not 2 or 3");

  a_internal_one : assert property (@(posedge clk) disable iff (!rst_n)
    take && is_cust && cnt_internal == CW'(1) && cnt_fetch == '0
    && cnt_branch == '0 && cnt_stack == '0 && cnt_byte == '0
    && cnt_word == '0 |-> ##3 total_ff == TW'(1))
    else $error("internal cycle not 1 state");

  // ==========================================================
  // Preset class checks
  a_alu_two : assert property (@(posedge clk) disable iff (!rst_n)
    s_take(IST_CLS_ALU_REG) |-> ##3 total_ff == TW'(2))
    else $error("register op total not 2");

  a_imm16_four : assert property (@(posedge clk) disable iff (!rst_n)
    s_take(IST_CLS_IMM16) |-> ##3 total_ff == TW'(4))
    else $error("16-bit immediate total not 4");

  a_branch_four : assert property (@(posedge clk) disable iff (!rst_n)
    s_take(IST_CLS_BRANCH) |-> ##3 total_ff == TW'(4))
    else $error("short branch total not 4");

  a_call_split : assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == IST_CALC && cls_ff == IST_CLS_CALL |->
    ci_ff == CW'(2) && cj_ff == CW'(1) && ck_ff == CW'(1) && cl_ff == '0
    && cm_ff == '0 && cn_ff == '0)
    else $error("indirect call split wrong");

  a_bitset_fetch : assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == IST_CALC && cls_ff == IST_CLS_BITSET |->
    ci_ff == CW'(2) && cl_ff == CW'(2))
    else $error("bit-set fetch or byte count wrong");

  // ==========================================================
  // Sequencing checks
  a_busy_refused : assert property (@(posedge clk) disable iff (!rst_n)
    !ready |=> $stable(cls_ff) && $stable(ci_ff) && $stable(cl_ff))
    else $error("request taken while busy");

  a_zero_done : assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == IST_CALC && sum == '0 |=> done_ff && !state_tick)
    else $error("empty instruction did not finish at once");

  a_done_pulse : assert property (@(posedge clk) disable iff (!rst_n)
    done_ff |=> !done_ff && ready)
    else $error("done not a single pulse");

  a_tick_remain : assert property (@(posedge clk) disable iff (!rst_n)
    state_tick |-> remain_ff != '0 && remain_ff <= total_ff)
    else $error("state counted past total");
endmodule : ist_timing

// ==== rtl/ist_defs.svh ====
// Timing constants for the instruction state timing block
`ifndef IST_DEFS_SVH
`define IST_DEFS_SVH
`define IST_CNT_W         4
`define IST_COST_W        2
`define IST_TOT_W         8
`define IST_PID_W         4
`define IST_MEM_COST      2'h2
`define IST_INT_COST      2'h1
`define IST_PER_COST_LO   2'h2
`define IST_PER_COST_HI   2'h3
`define IST_SLOW_MAP      16'h00f0
`endif

// ==== rtl/ist_pkg.sv ====
// Types for the instruction state timing block
package ist_pkg;
  typedef enum logic [2:0] {
    IST_CLS_CUSTOM  = 3'h0,
    IST_CLS_ALU_REG = 3'h1,
    IST_CLS_IMM16   = 3'h2,
    IST_CLS_IMM32   = 3'h3,
    IST_CLS_BRANCH  = 3'h4,
    IST_CLS_BITSET  = 3'h5,
    IST_CLS_CALL    = 3'h6
  } ist_class_t;

  typedef enum logic [4:0] {
    IST_IDLE = 5'h01,
    IST_LOOK = 5'h02,
    IST_CALC = 5'h04,
    IST_RUN  = 5'h08,
    IST_DONE = 5'h10
  } ist_state_t;
endpackage : ist_pkg

// ==== rtl/ist_periph_cost.sv ====
// Per-peripheral byte and word access state cost table, registered read
`timescale 1ns/10ps
`include "ist_defs.svh"
module ist_periph_cost
  import ist_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [`IST_PID_W-1:0]    pid,
  output logic      [`IST_COST_W-1:0]   cost_ff
);
  localparam logic [15:0] SLOW_MAP = `IST_SLOW_MAP;

  wire logic [`IST_COST_W-1:0] nxt_cost;
  assign nxt_cost = SLOW_MAP[pid] ? `IST_PER_COST_HI : `IST_PER_COST_LO;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cost_ff <= `IST_PER_COST_LO;
    end else begin
      cost_ff <= nxt_cost;
    end
  end

  a_cost_range : assert property (@(posedge clk) disable iff (!rst_n)
    cost_ff == $past(nxt_cost) && (cost_ff == `IST_PER_COST_LO ||
    cost_ff == `IST_PER_COST_HI)) else $error("bad peripheral cost");
endmodule : ist_periph_cost

// ==== sim/ist_periph_model.sv ====
// Peripheral side model: addressed module and its data state cost
`timescale 1ns/10ps
`include "ist_defs.svh"
module ist_periph_model (
  input  wire logic [4:0]            sel,
  output logic                       data_periph,
  output logic [`IST_PID_W-1:0]      periph_id,
  output int                         cost
);
  assign data_periph = sel[4];
  assign periph_id   = sel[3:0];
  // Modules four to seven are the slow ones
  assign cost = !sel[4] ? 2 : (sel[3:2] == 2'h1) ? 3 : 2;
endmodule : ist_periph_model

// ==== sim/testbench.sv ====
// Self-checking bench for the instruction state timing block
`timescale 1ns/10ps
`include "ist_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module testbench
  import ist_pkg::*;
;
  // ==========================================
  // Signals
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   start = 1'b0;
  ist_class_t             cls = IST_CLS_CUSTOM;
  logic [`IST_CNT_W-1:0]  cnt [6];
  logic [4:0]             sel = 5'h00;
  logic                   data_periph;
  logic [`IST_PID_W-1:0]  periph_id;
  logic                   ready;
  logic                   state_tick;
  logic                   done_ff;
  logic [`IST_TOT_W-1:0]  total_ff;
  int                     pcost;
  int                     errors = 0;
  int                     tests_run = 0;
  int                     cyc = 0;
  logic [31:0]            seed = 32'h0001855d;

  always #25 clk = ~clk;

  ist_periph_model peri (.sel(sel), .data_periph(data_periph),
    .periph_id(periph_id), .cost(pcost));

  ist_timing uut (.clk(clk), .rst_n(rst_n), .start(start), .cls(cls),
    .cnt_fetch(cnt[0]), .cnt_branch(cnt[1]), .cnt_stack(cnt[2]),
    .cnt_byte(cnt[3]), .cnt_word(cnt[4]), .cnt_internal(cnt[5]),
    .data_periph(data_periph), .periph_id(periph_id), .ready(ready),
    .state_tick(state_tick), .done_ff(done_ff), .total_ff(total_ff));

  // ==========================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic print_verdict;
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // Start held one extra cycle: the busy-cycle request must be ignored
  task automatic run(input ist_class_t c, input int e);
    logic [7:0] ticks;
    int         n;
    ticks = 8'h00;
    n = 0;
    @(posedge clk);
    #1 cls = c;
    start = 1'b1;
    if (e < 0)
      e = 2 * (cnt[0] + cnt[1] + cnt[2]) + pcost * (cnt[3] + cnt[4])
          + cnt[5];
    @(posedge clk);
    #1 `CHK(ready, 1'b0)
    @(posedge clk);
    #1 start = 1'b0;
    while (done_ff !== 1'b1 && n < 300) begin
      if (state_tick === 1'b1) ticks++;
      @(posedge clk);
      #1 n++;
    end
    `CHK(done_ff, 1'b1)
    `CHK(total_ff, 8'(e))
    `CHK(ticks, 8'(e))
  endtask : run

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    foreach (cnt[i]) cnt[i] = 4'h0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    run(IST_CLS_ALU_REG, 2);
    run(IST_CLS_IMM16, 4);
    run(IST_CLS_IMM32, 6);
    run(IST_CLS_BRANCH, 4);
    run(IST_CLS_BITSET, 8);
    run(IST_CLS_CALL, 8);
    cnt[3] = 4'h1;
    sel = 5'h15;
    run(IST_CLS_CUSTOM, 3);
    sel = 5'h1a;
    run(IST_CLS_CUSTOM, 2);
    sel = 5'h05;
    run(IST_CLS_CUSTOM, 2);
    cnt[3] = 4'h0;
    cnt[5] = 4'h1;
    run(IST_CLS_CUSTOM, 1);
    cnt[5] = 4'h0;
    run(IST_CLS_CUSTOM, 0);
    foreach (cnt[i]) cnt[i] = 4'hf;
    sel = 5'h17;
    run(IST_CLS_CUSTOM, 195);
    repeat (40) begin
      foreach (cnt[i]) begin
        seed = xs(seed);
        cnt[i] = seed[3:0];
      end
      seed = xs(seed);
      sel = seed[4:0];
      run(IST_CLS_CUSTOM, -1);
    end
    print_verdict();
  end
endmodule : testbench
